// >>> rtl/htc_map.vh
`ifndef HTC_MAP_VH
`define HTC_MAP_VH
// calibration memory layout: row index and field position
`define HTC_ROW_TL 0
`define HTC_TL_LSB 0
`define HTC_TL_W 9
`define HTC_ROW_TR 0
`define HTC_TR_LSB 9
`define HTC_TR_W 3
`define HTC_ROW_TQ 1
`define HTC_TQ_LSB 0
`define HTC_TQ_W 8
`define HTC_ROW_GAIN 2
`define HTC_ROW_OFS 3
`define HTC_ROW_CL 4
`define HTC_ROW_CH 5
`define HTC_FIELD_LSB 0
`define HTC_GAIN_W 15
`define HTC_CLAMP_W 12
// arithmetic constants
`define HTC_TL_BIAS 10'sd160
`define HTC_TQ_BIAS 9'sd128
`define HTC_T0_STEP_SH 4
`define HTC_T0_BIAS 8'sd32
`define HTC_S_FRAC 23
`define HTC_S_ONE 30'sd8388608
`define HTC_TC1_ALIGN 7
`define HTC_GAIN_BIAS 16'sd16384
`define HTC_GAIN_FRAC 12
`define HTC_OUT_MAX 12'hfff
`define HTC_OUT_MIN 12'h000
`endif

// >>> rtl/htc_buf2.v
`timescale 1ns/10ps
`default_nettype none
module htc_buf2 #(
	parameter W = 12
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire in_valid_in,
	input wire [W-1:0] in_data_in,
	output reg in_ready_out,
	output reg out_valid_out,
	output reg [W-1:0] out_data_out,
	input wire out_ready_in
);
	reg [1:0] cnt;
	reg [1:0] next_cnt;
	reg [W-1:0] tail;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;

	always @* begin
		next_cnt = cnt;
		if (push && !pop)
			next_cnt = cnt + 2'd1;
		else if (pop && !push)
			next_cnt = cnt - 2'd1;
	end

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt <= 2'd0;
			tail <= {W{1'b0}};
			out_data_out <= {W{1'b0}};
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			in_ready_out <= (next_cnt != 2'd2);
			out_valid_out <= (next_cnt != 2'd0);
			if (cnt == 2'd2 && pop)
				out_data_out <= tail;
			else if (push && (cnt == 2'd0 || pop))
				out_data_out <= in_data_in;
			else if (push)
				tail <= in_data_in;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/htc_core.v
`timescale 1ns/10ps
`default_nettype none
`include "htc_map.vh"
module htc_core #(
	parameter ROWS = 6,
	parameter ROW_W = 16,
	parameter HALL_W = 16,
	parameter TEMP_W = 8
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire mem_load_in,
	input wire [ROWS*(ROW_W+1)-1:0] mem_rows_in,
	input wire [ROW_W-1:0] mem_col_par_in,
	input wire temp_valid_in,
	input wire [TEMP_W-1:0] temp_in,
	input wire hall_valid_in,
	input wire [HALL_W-1:0] hall_in,
	input wire field_over_range_in,
	input wire overvoltage_in,
	input wire undervoltage_in,
	input wire out_ready_in,
	output wire hall_ready_out,
	output wire out_valid_out,
	output wire [`HTC_CLAMP_W-1:0] out_code_out,
	output reg params_valid_out,
	output reg mem_corrected_out,
	output reg mem_fault_out,
	output reg supply_fault_out
);
	// ****************************************
	// calibration memory check and repair
	// ****************************************
	reg [ROWS-1:0] row_bad;
	reg [ROW_W-1:0] col_sum;
	reg [ROW_W-1:0] col_bad;
	reg [ROWS*ROW_W-1:0] fixed;
	reg single_fix;
	reg uncorrectable;
	integer r;
	integer c;
	integer n_rows;
	integer n_cols;

	always @* begin
		col_sum = mem_col_par_in;
		n_rows = 0;
		n_cols = 0;
		for (r = 0; r < ROWS; r = r + 1) begin
			// odd row parity: even count means a bad row
			row_bad[r] = ~^mem_rows_in[r*(ROW_W+1) +: ROW_W+1];
			col_sum = col_sum ^ mem_rows_in[r*(ROW_W+1) +: ROW_W];
			if (row_bad[r])
				n_rows = n_rows + 1;
		end
		for (c = 0; c < ROW_W; c = c + 1) begin
			// even columns want even sum, odd columns odd sum
			col_bad[c] = (c % 2 == 0) ? col_sum[c] : ~col_sum[c];
			if (col_bad[c])
				n_cols = n_cols + 1;
		end
		single_fix = (n_rows == 1) && (n_cols == 1);
		uncorrectable = (n_rows > 1) || (n_cols > 1);
		for (r = 0; r < ROWS; r = r + 1) begin
			fixed[r*ROW_W +: ROW_W] = mem_rows_in[r*(ROW_W+1) +: ROW_W]
				^ ((single_fix && row_bad[r]) ? col_bad : {ROW_W{1'b0}});
		end
	end

	// ****************************************
	// working copies of the stored codes
	// ****************************************
	reg [`HTC_TL_W-1:0] linear_temp_coeff;
	reg [`HTC_TQ_W-1:0] quadratic_temp_coeff;
	reg [`HTC_TR_W-1:0] reference_temp_sel;
	reg [`HTC_GAIN_W-1:0] gain_code;
	reg [`HTC_GAIN_W-1:0] offset_code;
	reg [`HTC_CLAMP_W-1:0] clamp_low_code;
	reg [`HTC_CLAMP_W-1:0] clamp_high_code;
	reg signed [TEMP_W-1:0] temp;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			linear_temp_coeff <= {`HTC_TL_W{1'b0}};
			quadratic_temp_coeff <= {`HTC_TQ_W{1'b0}};
			reference_temp_sel <= {`HTC_TR_W{1'b0}};
			gain_code <= {`HTC_GAIN_W{1'b0}};
			offset_code <= {`HTC_GAIN_W{1'b0}};
			clamp_low_code <= {`HTC_CLAMP_W{1'b0}};
			clamp_high_code <= {`HTC_CLAMP_W{1'b0}};
			params_valid_out <= 1'b0;
			mem_corrected_out <= 1'b0;
			mem_fault_out <= 1'b0;
			supply_fault_out <= 1'b0;
			temp <= {TEMP_W{1'b0}};
		end else begin
			supply_fault_out <= overvoltage_in | undervoltage_in;
			if (temp_valid_in)
				temp <= temp_in;
			if (mem_load_in) begin
				linear_temp_coeff <= fixed[`HTC_ROW_TL*ROW_W+`HTC_TL_LSB +: `HTC_TL_W];
				reference_temp_sel <= fixed[`HTC_ROW_TR*ROW_W+`HTC_TR_LSB +: `HTC_TR_W];
				quadratic_temp_coeff <= fixed[`HTC_ROW_TQ*ROW_W+`HTC_TQ_LSB +: `HTC_TQ_W];
				gain_code <= fixed[`HTC_ROW_GAIN*ROW_W+`HTC_FIELD_LSB +: `HTC_GAIN_W];
				offset_code <= fixed[`HTC_ROW_OFS*ROW_W+`HTC_FIELD_LSB +: `HTC_GAIN_W];
				clamp_low_code <= fixed[`HTC_ROW_CL*ROW_W+`HTC_FIELD_LSB +: `HTC_CLAMP_W];
				clamp_high_code <= fixed[`HTC_ROW_CH*ROW_W+`HTC_FIELD_LSB +: `HTC_CLAMP_W];
				params_valid_out <= 1'b1; // stored codes used as the base
				mem_corrected_out <= single_fix;
			end
			if (mem_load_in && uncorrectable)
				mem_fault_out <= 1'b1; // sticky until reset
		end
	end

	// ****************************************
	// temperature compensation datapath
	// ****************************************
	// no state in here: same inputs give same code
	wire signed [9:0] tc1;
	wire signed [8:0] tc2;
	wire [7:0] ref_scaled;
	wire signed [7:0] t0;
	wire signed [9:0] temp_x;
	wire signed [9:0] t0_x;
	wire signed [9:0] dev;
	wire signed [19:0] dev_sq;
	wire signed [29:0] term1;
	wire signed [29:0] term2;
	wire signed [29:0] temp_sensitivity_factor;
	wire signed [HALL_W+29:0] hall_comp_full;
	wire signed [HALL_W+29:0] hall_comp;
	wire signed [15:0] gain;
	wire signed [15:0] offs;
	wire signed [HALL_W+45:0] gained_full;
	wire signed [HALL_W+45:0] gained;
	wire signed [HALL_W+45:0] offs_x;
	wire signed [HALL_W+45:0] result;
	wire signed [HALL_W+45:0] lim_lo;
	wire signed [HALL_W+45:0] lim_hi;

	assign tc1 = $signed({1'b0, linear_temp_coeff}) - `HTC_TL_BIAS;
	assign tc2 = $signed({1'b0, quadratic_temp_coeff}) - `HTC_TQ_BIAS;
	assign ref_scaled = {5'h00, reference_temp_sel} << `HTC_T0_STEP_SH;
	assign t0 = $signed(ref_scaled) - `HTC_T0_BIAS;
	// sign extension spelled out
	assign temp_x = {{(10-TEMP_W){temp[TEMP_W-1]}}, temp};
	assign t0_x = {{2{t0[7]}}, t0};
	assign dev = temp_x - t0_x;
	assign dev_sq = dev * dev;
	assign term1 = tc1 * dev;
	assign term2 = tc2 * dev_sq;
	// factor scaled by 2^23; c1 term realigned from 2^16
	assign temp_sensitivity_factor = `HTC_S_ONE
		+ (term1 <<< `HTC_TC1_ALIGN) + term2;
	assign hall_comp_full = $signed(hall_in) * temp_sensitivity_factor;
	assign hall_comp = hall_comp_full >>> `HTC_S_FRAC;
	assign gain = $signed({1'b0, gain_code}) - `HTC_GAIN_BIAS;
	assign offs = $signed({1'b0, offset_code}) - `HTC_GAIN_BIAS;
	assign gained_full = hall_comp * gain;
	assign gained = gained_full >>> `HTC_GAIN_FRAC;
	assign offs_x = {{(HALL_W+30){offs[15]}}, offs};
	assign result = gained + offs_x;
	assign lim_lo = {{(HALL_W+34){1'b0}}, clamp_low_code};
	assign lim_hi = {{(HALL_W+34){1'b0}}, clamp_high_code};

	// ****************************************
	// output code selection, faults first
	// ****************************************
	reg [`HTC_CLAMP_W-1:0] next_code;

	always @* begin
		if (mem_fault_out || overvoltage_in)
			next_code = `HTC_OUT_MAX; // rail on fault
		else if (undervoltage_in)
			next_code = `HTC_OUT_MIN;
		else if (field_over_range_in)
			next_code = hall_in[HALL_W-1] ? clamp_low_code : clamp_high_code;
		else if (result < lim_lo)
			next_code = clamp_low_code;
		else if (result > lim_hi)
			next_code = clamp_high_code;
		else
			next_code = result[`HTC_CLAMP_W-1:0];
	end

	// ****************************************
	// output buffer towards the DAC
	// ****************************************
	// samples are ignored until the codes are loaded
	wire sample_valid;
	assign sample_valid = hall_valid_in & params_valid_out;

	htc_buf2 #(
		.W(`HTC_CLAMP_W)
	) u_buf (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(sample_valid),
		.in_data_in(next_code),
		.in_ready_out(hall_ready_out),
		.out_valid_out(out_valid_out),
		.out_data_out(out_code_out),
		.out_ready_in(out_ready_in)
	);
endmodule
`default_nettype wire

// >>> tb/htc_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module htc_core_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mem_load_in,
	input wire logic hall_valid_in,
	input wire logic overvoltage_in,
	input wire logic undervoltage_in,
	input wire logic out_ready_in,
	input wire logic hall_ready_out,
	input wire logic out_valid_out,
	input wire logic [11:0] out_code_out,
	input wire logic params_valid_out,
	input wire logic mem_fault_out,
	input wire logic supply_fault_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// sample taken into an empty buffer
	wire tk = hall_valid_in && hall_ready_out && params_valid_out && !out_valid_out;
	property p_mf_hold;
		mem_fault_out |=> mem_fault_out;
	endproperty
	a_mf_hold: assert property (p_mf_hold) else $error("memory fault dropped");
	property p_mf_rail;
		tk && mem_fault_out |=> out_code_out == 12'hfff;
	endproperty
	a_mf_rail: assert property (p_mf_rail) else $error("memory fault not at rail");
	property p_ov_rail;
		tk && overvoltage_in |=> out_code_out == 12'hfff;
	endproperty
	a_ov_rail: assert property (p_ov_rail) else $error("overvoltage not at rail");
	property p_uv_zero;
		tk && undervoltage_in && !overvoltage_in && !mem_fault_out |=> out_code_out == 12'h000;
	endproperty
	a_uv_zero: assert property (p_uv_zero) else $error("undervoltage code wrong");
	property p_answer;
		tk |=> out_valid_out;
	endproperty
	a_answer: assert property (p_answer) else $error("no code after sample");
	property p_hold;
		out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_code_out);
	endproperty
	a_hold: assert property (p_hold) else $error("code lost during stall");
	property p_load;
		mem_load_in |=> params_valid_out;
	endproperty
	a_load: assert property (p_load) else $error("codes not valid after load");
	property p_supply;
		1'b1 |=> supply_fault_out == $past(overvoltage_in || undervoltage_in);
	endproperty
	a_supply: assert property (p_supply) else $error("supply flag wrong");
	c_fault: cover property (tk && mem_fault_out);
	c_full: cover property (hall_valid_in && !hall_ready_out);
	c_ov: cover property (tk && overvoltage_in);
endmodule
bind htc_core htc_core_chk u_chk (.clk_in, .rst_n_in, .mem_load_in, .hall_valid_in,
	.overvoltage_in, .undervoltage_in, .out_ready_in, .hall_ready_out, .out_valid_out,
	.out_code_out, .params_valid_out, .mem_fault_out, .supply_fault_out);
`default_nettype wire

// >>> tb/htc_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module htc_adc_model (
	input wire logic clk_in,
	input wire logic slow_in,
	output logic ready_out
);
	int seed = 32'h4c52bd8e;
	// converter reads promptly, or one time in four when slow
	always @(negedge clk_in) begin
		ready_out <= !slow_in || ($random(seed) & 3) == 0;
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_in = 0, rst_n_in = 0, mem_load_in = 0, temp_valid_in = 0, hall_valid_in = 0;
	logic field_over_range_in = 0, overvoltage_in = 0, undervoltage_in = 0, slow = 0;
	logic [101:0] mem_rows_in = 0;
	logic [15:0] mem_col_par_in = 0, hall_in = 0;
	logic [7:0] temp_in = 0;
	wire out_ready_in, hall_ready_out, out_valid_out, params_valid_out;
	wire mem_corrected_out, mem_fault_out, supply_fault_out;
	wire [11:0] out_code_out;
	int n_fail = 0, samples_checked = 0, seed = 32'h4c52bd8e, bad = 0;
	int tl, tq, tr, g = 20480, os = 18432, cl = 256, ch = 3840;
	logic [11:0] q[$];
	always #20 clk_in = ~clk_in;
	htc_core dut (.*);
	htc_adc_model adc (.clk_in, .slow_in(slow), .ready_out(out_ready_in));
	task chk(string nm, logic [11:0] seen, logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	function logic [11:0] model_code(int h, int t);
		longint dt, p;
		dt = t - (16 * tr - 32);
		p = (64'sd1 <<< 23) + (((tl - 160) * dt) <<< 7) + (tq - 128) * dt * dt;
		p = ((h * p) >>> 23) * (g - 16384) >>> 12;
		p = p + os - 16384;
		if (bad || overvoltage_in) return 12'hfff;
		if (undervoltage_in) return 12'h000;
		if (field_over_range_in) return h < 0 ? cl[11:0] : ch[11:0];
		return p < cl ? cl[11:0] : p > ch ? ch[11:0] : p[11:0];
	endfunction
	task load_mem(int flips);
		logic [15:0] d [6];
		d = '{{4'h0, tr[2:0], tl[8:0]}, tq[15:0], g[15:0], os[15:0], cl[15:0], ch[15:0]};
		mem_col_par_in = 16'haaaa;
		for (int r = 0; r < 6; r++) begin
			mem_rows_in[r*17+:17] = {~^d[r], d[r]};
			mem_col_par_in ^= d[r];
		end
		if (flips > 0) mem_rows_in[3] ^= 1'b1;
		if (flips > 1) mem_rows_in[22] ^= 1'b1;
		@(negedge clk_in) mem_load_in = 1;
		@(negedge clk_in) mem_load_in = 0;
		if (flips < 2) chk("corrected", mem_corrected_out, flips == 1);
		chk("fault", mem_fault_out, bad[0]);
		chk("params", params_valid_out, 1);
	endtask
	task send(int n, int t);
		int h;
		@(negedge clk_in) temp_valid_in = 1;
		temp_in = t[7:0];
		@(negedge clk_in) temp_valid_in = 0;
		repeat (n) begin
			h = $random(seed) % 3000;
			hall_in = h[15:0];
			hall_valid_in = 1;
			while (!hall_ready_out) @(negedge clk_in);
			q.push_back(model_code(h, t));
			@(negedge clk_in);
		end
		hall_valid_in = 0;
	endtask
	task fin(int k);
		repeat (300) if (q.size() != 0) @(negedge clk_in);
		chk("drained", 12'(q.size()), 12'h000);
		$display("test %0d done", k);
	endtask
	task conclude;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_in) begin
		if (rst_n_in && out_valid_out && out_ready_in)
			chk("code", out_code_out, q.size() ? q.pop_front() : 12'hx);
	end
	initial begin
		#800000;
		n_fail++;
		conclude();
	end
	initial begin
		repeat (10) @(negedge clk_in);
		rst_n_in = 1;
		for (int i = 0; i < 8; i++) begin
			tr = i;
			tl = 100 + 50 * i;
			tq = 120 + 3 * i;
			g = 18432 + 512 * i;
			os = 17408 + 256 * i;
			slow = i[0];
			load_mem(0);
			send(6, $random(seed) % 100);
		end
		fin(1);
		field_over_range_in = 1;
		send(6, 25);
		field_over_range_in = 0;
		fin(2);
		load_mem(1);
		send(4, 25);
		fin(3);
		overvoltage_in = 1;
		@(negedge clk_in) chk("supply", supply_fault_out, 1);
		send(3, 25);
		overvoltage_in = 0;
		undervoltage_in = 1;
		send(3, 25);
		undervoltage_in = 0;
		fin(4);
		bad = 1;
		load_mem(2);
		send(3, 25);
		load_mem(0);
		send(3, 25);
		fin(5);
		conclude();
	end
endmodule
`default_nettype wire
